// >>> hdl/swd_watchdog.sv
// Purpose : software watchdog timer with toggle-sequence control
// Assumes : cpu writes the control register through a byte write strobe;
//           the timebase tick comes from logic on the same clock
// Notes   : expiry action strap is sampled once after reset release
`timescale 1ns/100ps

// Overview of operation
// R1: expiry resets device or flags interrupt per strap
// R2: strap selects action only, software arms
// R3: bit 7 one-then-zero arms the countdown
// R4: countdown is timeout field plus one ticks
// R5: expiry may come one tick late
// R6: new timeout used at next expiry or restart
// R7: bit 5 one-then-zero reloads the counter
// R8: software restarts faster than the countdown period
// R9: armed watchdog counts until disarm or reset
// R10: bit 6 one-then-zero disarms until rearmed
// R11: watchdog reset restarts the whole device
// R12: interrupt flag, enables gate vector 0063 hex
// R13: flag stays until software clears it
// R14: idle wake only with wake enable set
// R15: strap fixed at programming, defaults to reset
// R16: toggle seen when written one becomes zero
// R17: after reset disarmed, flag and timeout clear
module swd_watchdog (
  input  wire logic                      ref_clk_i,          // system clock
  input  wire logic                      rst_i,              // device reset
  input  wire logic                      ctrl_wr_i,          // write strobe
  input  wire logic [swd_pkg::CTRL_W-1:0] ctrl_wdata_i,      // write byte
  input  wire logic                      tick_i,             // timebase tick
  input  wire logic                      expiry_reset_select_i, // strap
  input  wire logic                      flag_clear_i,       // sw clears flag
  input  wire logic                      expiry_interrupt_enable_i,
  input  wire logic                      global_interrupt_enable_i,
  input  wire logic                      idle_wake_on_expiry_i,
  input  wire logic                      cpu_idle_i,         // cpu in idle
  output logic [swd_pkg::CTRL_W-1:0]     ctrl_rdata_o,       // register view
  output logic                           armed_o,            // counting
  output logic                           expiry_interrupt_flag_o,
  output logic                           irq_request_o,      // to cpu
  output logic [15:0]                    irq_vector_o,       // target addr
  output logic                           idle_wake_o,        // leave idle
  output logic                           wdt_reset_req_o     // device reset
);
  import swd_pkg::*;

  // control register and derived state
  logic [CTRL_W-1:0] ctrl_reg;       // watchdog_control as last written
  logic              armed_reg;      // countdown running
  logic              strap_reg;      // captured expiry_reset_select
  logic              strap_done_reg; // strap captured since reset
  logic              load_reg;       // reload request to the counter
  logic              flag_reg;       // expiry_interrupt_flag
  logic              flag_next;      // next flag value
  logic              reset_req_reg;  // held watchdog reset request
  logic              irq_reg;        // registered interrupt request
  logic              wake_reg;       // registered idle wake
  logic [15:0]       vector_reg;     // registered vector
  logic [CTRL_W-1:0] rdata_reg;      // registered read view

  // toggle events decoded from the write itself
  logic arm_evt;                     // arm sequence completed
  logic dis_evt;                     // disarm sequence completed
  logic rst_evt;                     // restart sequence completed

  swd_cnt_if cnt_bus ();             // link to the countdown

  // a toggle is a stored one overwritten by a zero; a zero written over
  // a zero does nothing, so plain timeout updates never disturb the timer
  assign arm_evt = ctrl_wr_i && ctrl_reg[ARM_TOGGLE_BIT] &&
                   !ctrl_wdata_i[ARM_TOGGLE_BIT];            // [R3] [R16]
  assign dis_evt = ctrl_wr_i && ctrl_reg[DIS_TOGGLE_BIT] &&
                   !ctrl_wdata_i[DIS_TOGGLE_BIT];            // [R10] [R16]
  assign rst_evt = ctrl_wr_i && ctrl_reg[RST_TOGGLE_BIT] &&
                   !ctrl_wdata_i[RST_TOGGLE_BIT];            // [R7] [R16]

  // control register holds the byte as written
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RESET;                                // [R17]
    end else if (ctrl_wr_i) begin
      ctrl_reg <= ctrl_wdata_i;
    end
  end

  // strap capture: the configuration pin is static, but it is read by a
  // clock edge after release so the async reset only loads constants
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_reg      <= EXPIRY_RESET_DEFAULT;                // [R15]
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_reg      <= expiry_reset_select_i;               // [R15]
      strap_done_reg <= 1'b1;
    end
  end

  // run state: only software sequences decide it; the strap never does
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_reg <= 1'b0;                                     // [R17]
    end else if (dis_evt) begin
      armed_reg <= 1'b0;             // disarm wins a double toggle [R10]
    end else if (arm_evt) begin
      armed_reg <= 1'b1;                                     // [R2] [R3]
    end
  end

  // reload on arm or restart, one cycle later so the new timeout byte
  // is already in the control register when the counter samples it
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      load_reg <= 1'b0;
    end else begin
      load_reg <= !dis_evt && (arm_evt || (rst_evt && armed_reg)); // [R7]
    end
  end

  // counter connections
  assign cnt_bus.run      = armed_reg;                       // [R9]
  assign cnt_bus.load     = load_reg;
  assign cnt_bus.load_val = CNT_W'(ctrl_reg[TIMEOUT_W-1:0])
                            + CNT_MARGIN;                    // [R4] [R5]
  assign cnt_bus.tick     = tick_i;

  swd_countdown u_countdown (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .cnt_if    (cnt_bus)
  );

  // interrupt flag: set beats a simultaneous clear so no expiry is lost
  always_comb begin
    flag_next = flag_reg;
    if (flag_clear_i) begin
      flag_next = 1'b0;                                      // [R13]
    end
    if (cnt_bus.expire && !strap_reg) begin
      flag_next = 1'b1;                                      // [R1] [R12]
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_reg <= 1'b0;                                      // [R17]
    end else begin
      flag_reg <= flag_next;
    end
  end

  // watchdog reset request: held until the system reset lands on rst_i,
  // which resets every register here like the rest of the device
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_req_reg <= 1'b0;
    end else if (cnt_bus.expire && strap_reg) begin
      reset_req_reg <= 1'b1;                                 // [R1] [R11]
    end
  end

  // interrupt request stays high while the flag and both enables are set, so an uncleared
  // flag requests the interrupt again after return
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_reg    <= 1'b0;
      vector_reg <= VECTOR_NONE;
    end else begin
      irq_reg    <= flag_reg && expiry_interrupt_enable_i &&
                    global_interrupt_enable_i;               // [R12] [R13]
      vector_reg <= EXPIRY_VECTOR;                           // [R12]
    end
  end

  // idle wake: a pending interrupt wakes the cpu only with wake enabled
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= cpu_idle_i && idle_wake_on_expiry_i && flag_reg &&
                  expiry_interrupt_enable_i &&
                  global_interrupt_enable_i;                 // [R14]
    end
  end

  // read view of the control register
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= CTRL_RESET;
    end else begin
      rdata_reg <= ctrl_wr_i ? ctrl_wdata_i : ctrl_reg;
    end
  end

  // outputs, all straight from flip-flops
  assign ctrl_rdata_o            = rdata_reg;
  assign armed_o                 = armed_reg;
  assign expiry_interrupt_flag_o = flag_reg;
  assign irq_request_o           = irq_reg;
  assign irq_vector_o            = vector_reg;
  assign idle_wake_o             = wake_reg;
  assign wdt_reset_req_o         = reset_req_reg;

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_arm;
    arm_evt && !dis_evt |-> ##1 armed_reg ##1
      cnt_bus.count == CNT_W'($past(ctrl_wdata_i[TIMEOUT_W-1:0], 2))
                       + CNT_MARGIN;
  endproperty
  a_arm: assert property (p_arm) // [R3]
    else $error("arm sequence did not load the countdown");

  property p_no_toggle;
    ctrl_wr_i && !ctrl_reg[ARM_TOGGLE_BIT] && !armed_reg |-> ##1 !armed_reg;
  endproperty
  a_no_toggle: assert property (p_no_toggle) // [R16]
    else $error("watchdog armed without a toggle");

  property p_disarm;
    dis_evt |-> ##1 !armed_reg ##1 cnt_bus.count == CNT_ZERO;
  endproperty
  a_disarm: assert property (p_disarm) // [R10]
    else $error("disarm sequence did not stop the watchdog");

  property p_keep_running;
    armed_reg && !dis_evt |-> ##1 armed_reg;
  endproperty
  a_keep_running: assert property (p_keep_running) // [R9]
    else $error("armed watchdog stopped by itself");

  property p_reset_mode;
    cnt_bus.expire && strap_reg |-> ##1 wdt_reset_req_o && !flag_reg;
  endproperty
  a_reset_mode: assert property (p_reset_mode) // [R1]
    else $error("expiry in reset mode did not request reset");

  property p_irq_mode;
    cnt_bus.expire && !strap_reg |-> ##1 flag_reg && !wdt_reset_req_o;
  endproperty
  a_irq_mode: assert property (p_irq_mode) // [R12]
    else $error("expiry in interrupt mode did not set the flag");

  property p_flag_sticky;
    flag_reg && !flag_clear_i |-> ##1 flag_reg;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) // [R13]
    else $error("interrupt flag dropped without a clear");

  property p_irq_gate;
    flag_reg && expiry_interrupt_enable_i && global_interrupt_enable_i
      |-> ##1 irq_request_o && irq_vector_o == EXPIRY_VECTOR;
  endproperty
  a_irq_gate: assert property (p_irq_gate) // [R12]
    else $error("enabled flag did not request the interrupt");

  property p_no_wake;
    !idle_wake_on_expiry_i |-> ##1 !idle_wake_o;
  endproperty
  a_no_wake: assert property (p_no_wake) // [R14]
    else $error("idle wake without wake enable");

  property p_restart;
    rst_evt && armed_reg && !dis_evt |-> ##2
      cnt_bus.count == CNT_W'($past(ctrl_wdata_i[TIMEOUT_W-1:0], 2))
                       + CNT_MARGIN;
  endproperty
  a_restart: assert property (p_restart) // [R7]
    else $error("restart did not reload the counter");

  property p_set_wins;
    cnt_bus.expire && !strap_reg && flag_clear_i |-> ##1 flag_reg;
  endproperty
  a_set_wins: assert property (p_set_wins) // [R13]
    else $error("clear beat a coinciding expiry");

  property p_flag_clear;
    flag_reg && flag_clear_i && !cnt_bus.expire |-> ##1 !flag_reg;
  endproperty
  a_flag_clear: assert property (p_flag_clear) // [R13]
    else $error("interrupt flag not cleared by software");

  property p_wake;
    cpu_idle_i && idle_wake_on_expiry_i && flag_reg &&
      expiry_interrupt_enable_i && global_interrupt_enable_i
      |-> ##1 idle_wake_o;
  endproperty
  a_wake: assert property (p_wake) // [R14]
    else $error("enabled idle wake did not fire");

  property p_irq_off;
    !flag_reg |-> ##1 !irq_request_o;
  endproperty
  a_irq_off: assert property (p_irq_off) // [R12]
    else $error("interrupt requested with the flag clear");

  property p_restart_idle;
    rst_evt && !armed_reg && !arm_evt |-> ##1 !load_reg;
  endproperty
  a_restart_idle: assert property (p_restart_idle) // [R7]
    else $error("restart reloaded a disarmed watchdog");

  c_arm: cover property (arm_evt ##[1:3] armed_reg);
  c_irq_expiry: cover property (cnt_bus.expire && !strap_reg);
  c_reset_expiry: cover property (cnt_bus.expire && strap_reg);
  c_set_clear: cover property (cnt_bus.expire && flag_clear_i);

endmodule : swd_watchdog

// >>> hdl/swd_pkg.sv
// Purpose : shared constants for the software watchdog timer
// Assumes : control register is written one byte at a time by the cpu
// Notes   : all bit positions and widths used by the design live here
package swd_pkg;

  // control register layout
  localparam int unsigned CTRL_W          = 8;     // register width
  localparam int unsigned ARM_TOGGLE_BIT  = 7;     // arm_toggle_bit
  localparam int unsigned DIS_TOGGLE_BIT  = 6;     // disarm_toggle_bit
  localparam int unsigned RST_TOGGLE_BIT  = 5;     // restart_toggle_bit
  localparam int unsigned TIMEOUT_W       = 5;     // timeout field width
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00; // control after reset

  // countdown counter
  localparam int unsigned CNT_W = 6;                 // holds timeout + 2
  // load margin: one for the +1 of the field, one so the partial first
  // tick never shortens the interval (expiry lands up to a tick late)
  localparam logic [CNT_W-1:0] CNT_MARGIN = 6'h02;
  localparam logic [CNT_W-1:0] CNT_ONE    = 6'h01;   // last count
  localparam logic [CNT_W-1:0] CNT_ZERO   = 6'h00;   // idle count

  // expiry action strap and interrupt vector
  localparam logic       EXPIRY_RESET_DEFAULT = 1'b1; // reset selected
  localparam logic [15:0] EXPIRY_VECTOR       = 16'h0063;
  localparam logic [15:0] VECTOR_NONE         = 16'h0000;

endpackage : swd_pkg

// >>> hdl/swd_cnt_if.sv
// Purpose : carries control and status between watchdog core and counter
// Assumes : single clock domain, driven by the watchdog top
// Notes   : ctl side belongs to the top, cnt side to the countdown
`timescale 1ns/100ps
interface swd_cnt_if;
  import swd_pkg::*;
  logic             run;       // counter armed
  logic             load;      // one-cycle reload request
  logic [CNT_W-1:0] load_val;  // reload value, timeout + margin
  logic             tick;      // timebase tick pulse
  logic             expire;    // one-cycle expiry pulse
  logic [CNT_W-1:0] count;     // current count, for status and checks

  modport ctl (output run, load, load_val, tick, input expire, count);
  modport cnt (input run, load, load_val, tick, output expire, count);
endinterface : swd_cnt_if

// >>> hdl/swd_countdown.sv
// Purpose : tick-driven countdown of the watchdog
// Assumes : tick is a one-cycle pulse on ref_clk_i
// Notes   : the reload value is sampled only on load or on expiry
`timescale 1ns/100ps
module swd_countdown (
  input  wire logic ref_clk_i,  // system clock
  input  wire logic rst_i,      // async reset, active high
  swd_cnt_if.cnt    cnt_if      // control from the watchdog top
);
  import swd_pkg::*;

  logic [CNT_W-1:0] count_reg;  // remaining ticks
  logic             expire_reg; // expiry pulse

  // countdown: stopped counter sits at zero and never expires
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= CNT_ZERO;
    end else if (!cnt_if.run) begin
      count_reg <= CNT_ZERO;
    end else if (cnt_if.load) begin
      count_reg <= cnt_if.load_val;       // restart picks up new timeout [R6]
    end else if (cnt_if.tick) begin
      if (count_reg == CNT_ONE) begin
        count_reg <= cnt_if.load_val;     // keeps running after expiry [R9]
      end else begin
        count_reg <= count_reg - CNT_ONE; // one tick gone [R4]
      end
    end
  end

  // expiry pulse on the tick that consumes the last count
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      expire_reg <= 1'b0;
    end else begin
      expire_reg <= cnt_if.run && !cnt_if.load && cnt_if.tick &&
                    (count_reg == CNT_ONE); // [R5]
    end
  end

  assign cnt_if.count  = count_reg;
  assign cnt_if.expire = expire_reg;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_count_down;
    cnt_if.run && cnt_if.tick && !cnt_if.load && (count_reg > CNT_ONE)
      ##1 cnt_if.run
      |-> count_reg == $past(count_reg) - CNT_ONE;
  endproperty
  a_count_down: assert property (p_count_down) // [R4]
    else $error("counter did not step down on a tick");

endmodule : swd_countdown

// >>> verif/swd_cpu_model.sv
// Purpose : cpu software model that writes the watchdog control register
// Assumes : one byte per write strobe, driven just after the rising edge
// Notes   : keeps a shadow of the byte last written, as software would
`timescale 1ns/100ps
module swd_cpu_model (
  input  wire logic                  ref_clk_i,    // system clock
  output logic                       ctrl_wr_o,    // write strobe
  output logic [swd_pkg::CTRL_W-1:0] ctrl_wdata_o, // byte written
  output logic                       flag_clear_o  // clears the flag
);
  import swd_pkg::*;

  logic [CTRL_W-1:0] shadow;  // software copy of the last byte written

  // idle values at time zero
  initial begin
    ctrl_wr_o    = 1'b0;
    ctrl_wdata_o = CTRL_RESET;
    flag_clear_o = 1'b0;
    shadow       = CTRL_RESET;
  end

  // one write, then data scrambled so a stale byte is never reused
  task automatic wr(input logic [CTRL_W-1:0] b, input int gap);
    @(posedge ref_clk_i);
    ctrl_wr_o    <= 1'b1;
    ctrl_wdata_o <= b;
    shadow        = b;
    @(posedge ref_clk_i);
    ctrl_wr_o    <= 1'b0;
    ctrl_wdata_o <= ~b;
    repeat (gap) @(posedge ref_clk_i);
  endtask

  // read-modify-write pair: set the bit, then clear it
  task automatic toggle(input logic [CTRL_W-1:0] mask, input int gap);
    wr(shadow | mask, gap);
    wr(shadow & ~mask, gap);
  endtask

  // handler clears the flag before it returns
  task automatic clr();
    @(posedge ref_clk_i);
    flag_clear_o <= 1'b1;
    @(posedge ref_clk_i);
    flag_clear_o <= 1'b0;
  endtask
endmodule // swd_cpu_model

// >>> verif/tb_swd_watchdog.sv
// Purpose : self-checking bench for the software watchdog timer
// Assumes : timebase tick every 4 clocks; device reset fed back from dut
// Notes   : table rows cover interrupt mode, hand tests the rest
`timescale 1ns/100ps
module tb_swd_watchdog;
  import swd_pkg::*;
  localparam int P = 4;  // clocks per timebase tick

  logic              ref_clk_i = 1'b0;      // system clock
  logic              rst_b = 1'b1;          // bench reset
  logic              rst_i;                 // bench or watchdog reset
  logic [2:0]        dcnt = 3'h0;           // device reset stretch
  logic [1:0]        tph = 2'h0;            // tick phase
  logic              tick = 1'b0;           // timebase tick
  logic              strap = 1'b0;          // expiry action select
  logic              ie = 1'b0, ge = 1'b0;  // interrupt enables
  logic              idl = 1'b0, wk = 1'b0; // idle and wake enable
  logic              wr, fclr;              // from cpu model
  logic [CTRL_W-1:0] wd, rd;                // write and read bytes
  logic              armed, flag, irq, wake, req;
  logic [15:0]       vec;
  int                error_cnt = 0, samples_checked = 0, cyc = 0;
  logic [10:0]       rows [0:4];            // t, ie, ge, idle, wk, irq, wake

  always #20 ref_clk_i = ~ref_clk_i;

  // tick generator on the system clock
  always @(posedge ref_clk_i) begin
    tph  <= tph + 2'h1;
    tick <= (tph == 2'h3);
  end

  // a watchdog reset request holds the device in reset a few clocks
  always @(posedge ref_clk_i) begin
    if (req === 1'b1) dcnt <= 3'h4;
    else if (dcnt != 3'h0) dcnt <= dcnt - 3'h1;
  end
  assign rst_i = rst_b | (dcnt != 3'h0);

  swd_cpu_model u_cpu (.ref_clk_i(ref_clk_i), .ctrl_wr_o(wr),
    .ctrl_wdata_o(wd), .flag_clear_o(fclr));

  swd_watchdog u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .ctrl_wr_i(wr), .ctrl_wdata_i(wd), .tick_i(tick),
    .expiry_reset_select_i(strap), .flag_clear_i(fclr),
    .expiry_interrupt_enable_i(ie), .global_interrupt_enable_i(ge),
    .idle_wake_on_expiry_i(wk), .cpu_idle_i(idl), .ctrl_rdata_o(rd),
    .armed_o(armed), .expiry_interrupt_flag_o(flag),
    .irq_request_o(irq), .irq_vector_o(vec), .idle_wake_o(wake),
    .wdt_reset_req_o(req));

  task automatic chk(input string nm, input logic [15:0] got,
                     input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // arm with timeout t, optionally rewrite timeout, wait for expiry
  task automatic run(input logic [4:0] t, input bit chg);
    int n;
    n = 0;
    u_cpu.wr(8'h80, 0);
    u_cpu.wr({3'h0, t}, 0);
    if (chg) u_cpu.wr(8'h00, 0);
    // look on the falling edge, where flag and request have settled
    while (flag !== 1'b1 && req !== 1'b1 && n < 400) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk("expiry_window", 16'(n >= (t + 1) * P && n <= (t + 2) * P + 8),
        16'h1);
  endtask

  // hang guard, far above the expected run length
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  initial begin
    logic [4:0] t;
    logic ei, ew;
    rows = '{{5'h00, 6'h32}, {5'h01, 6'h2c}, {5'h07, 6'h1c},
             {5'h1f, 6'h3f}, {5'h03, 6'h3a}};
    repeat (4) @(posedge ref_clk_i);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    // state straight after reset
    chk("armed", 16'(armed), 16'h0);
    chk("flag", 16'(flag), 16'h0);
    chk("rdata", 16'(rd), 16'h0);
    chk("vector", vec, EXPIRY_VECTOR);
    // interrupt mode table
    for (int i = 0; i < 5; i++) begin
      {t, ei, ew} = {rows[i][10:6], rows[i][1:0]};
      {ie, ge, idl, wk} <= rows[i][5:2];   // inputs move on the edge
      run(t, 1'b0);
      repeat (3) @(posedge ref_clk_i);
      chk("flag", 16'(flag), 16'h1);
      chk("reset_req", 16'(req), 16'h0);
      chk("irq", 16'(irq), 16'(ei));
      chk("wake", 16'(wake), 16'(ew));
      chk("rdata", 16'(rd), {11'h0, t});
      repeat (10) @(posedge ref_clk_i);
      chk("flag_sticky", 16'(flag), 16'h1);
      u_cpu.toggle(8'h40, 0);
      u_cpu.clr();
      repeat (2) @(posedge ref_clk_i);
      chk("flag_clr", 16'(flag), 16'h0);
      chk("armed", 16'(armed), 16'h0);
    end
    ie <= 1'b0;
    // zero writes with no prior one must not arm
    u_cpu.wr(8'h00, 0);
    u_cpu.wr(8'h00, 1);
    chk("armed_zero", 16'(armed), 16'h0);
    // arm then disarm at once: nothing may expire
    u_cpu.toggle(8'h80, 1);
    chk("armed", 16'(armed), 16'h1);
    u_cpu.toggle(8'h40, 1);
    chk("disarmed", 16'(armed), 16'h0);
    repeat (40) @(posedge ref_clk_i);
    chk("no_expiry", 16'(flag), 16'h0);
    // lowering the timeout after arming keeps the running count
    run(5'h07, 1'b1);
    u_cpu.toggle(8'h40, 0);
    u_cpu.clr();
    // frequent restarts keep it from expiring
    u_cpu.wr(8'h80, 0);
    u_cpu.wr(8'h02, 0);
    for (int k = 0; k < 10; k++) begin
      repeat (4) @(posedge ref_clk_i);
      u_cpu.toggle(8'h20, 0);
    end
    chk("restart_held", 16'(flag), 16'h0);
    u_cpu.toggle(8'h40, 0);
    // reset mode: strap set, captured after a fresh reset
    strap <= 1'b1;
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    run(5'h01, 1'b0);
    chk("reset_req", 16'(req), 16'h1);
    chk("flag_rm", 16'(flag), 16'h0);
    repeat (8) @(posedge ref_clk_i);
    chk("armed_rst", 16'(armed), 16'h0);
    chk("rdata_rst", 16'(rd), 16'h0);
    end_sim();
  end
endmodule // tb_swd_watchdog
